// >>> src/stop_wake_stabilization_counter.v
// Stop-release oscillator settling counter and standby controller
`timescale 1ns/1ps
`include "settle_defines.vh"
module stop_wake_stabilization_counter #(
  parameter [16:0] THR0 = `SETTLE_THR0,
  parameter [16:0] THR1 = `SETTLE_THR1,
  parameter [16:0] THR2 = `SETTLE_THR2,
  parameter [16:0] THR3 = `SETTLE_THR3,
  parameter [16:0] THR4 = `SETTLE_THR4
) (
  input wire mclk,
  input wire reset,
  input wire stop_exec,
  input wire halt_exec,
  input wire irq_pending,
  input wire main_crystal_osc_ok,
  input wire select_wr,
  input wire [2:0] select_wdata,
  output reg [2:0] settle_period_select_reg,
  output reg [4:0] settle_status_reg,
  output reg main_crystal_clock_en_r,
  output reg cpu_run_r,
  output reg stop_mode_r,
  output reg halt_mode_r,
  output reg settling_r
);
  localparam [2:0] S_RUN = `ST_RUN;
  localparam [2:0] S_STOP = `ST_STOP;
  localparam [2:0] S_OSC = `ST_OSC;
  localparam [2:0] S_COUNT = `ST_COUNT;
  localparam [2:0] S_HALT = `ST_HALT;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [16:0] cnt_r;
  reg [16:0] cnt_nxt;
  reg [4:0] status_nxt;
  wire osc_ok_s;
  reg osc_low_seen_r;
  integer i;

  // Threshold for a select code; codes above the top one take the longest
  function [16:0] thr_of;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: thr_of = THR0;
        3'h1: thr_of = THR1;
        3'h2: thr_of = THR2;
        3'h3: thr_of = THR3;
        default: thr_of = THR4;
      endcase
    end
  endfunction

  // Counting ends at the selected threshold; codes above the top take the longest
  function count_done;
    input [16:0] cnt;
    input [2:0] sel;
    begin
      count_done = (cnt >= thr_of(sel));
    end
  endfunction

  // Crystal enable drops only while fully stopped
  function clk_on_in;
    input [2:0] st;
    begin
      clk_on_in = (st != S_STOP);
    end
  endfunction

  // CPU executes only in the run state
  function run_in;
    input [2:0] st;
    begin
      run_in = (st == S_RUN);
    end
  endfunction

  // Stop state decode
  function stop_in;
    input [2:0] st;
    begin
      stop_in = (st == S_STOP);
    end
  endfunction

  // CPU is held in halt and while the settling count runs
  function held_in;
    input [2:0] st;
    begin
      held_in = (st == S_HALT) || (st == S_COUNT);
    end
  endfunction

  // Settling covers the wait for oscillation and the count
  function settle_in;
    input [2:0] st;
    begin
      settle_in = (st == S_COUNT) || (st == S_OSC);
    end
  endfunction

  // Oscillator-running flag comes from the pad side
  level_sync u_osc_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in(main_crystal_osc_ok),
    .sync_out_r(osc_ok_s)
  );

  // Next state, counter and status
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    status_nxt = settle_status_reg;
    case (state_r)
      S_RUN: begin
        if (stop_exec && irq_pending) begin
          // Oscillator never stops, so counting starts at once
          state_nxt = S_COUNT;
          cnt_nxt = 17'h00000;
          status_nxt = `SETTLE_STAT_RST;
        end else if (stop_exec) begin
          state_nxt = S_STOP;
        end else if (halt_exec && !irq_pending) begin
          state_nxt = S_HALT;
        end
      end
      S_STOP: begin
        // Any pending unmasked request releases stop; the count restarts from zero
        if (irq_pending) begin
          state_nxt = S_OSC;
          cnt_nxt = 17'h00000;
          status_nxt = `SETTLE_STAT_RST;
        end
      end
      S_OSC: begin
        // Time before oscillation starts is not part of the wait; a stale
        // high level left in the synchroniser from before the stop must not
        // count as a fresh start, so the flag has to have dropped first
        if (osc_ok_s && osc_low_seen_r) begin
          state_nxt = S_COUNT;
        end
      end
      S_COUNT: begin
        // Counter stops at the selected period and nowhere beyond
        if (count_done(cnt_r, settle_period_select_reg)) begin
          state_nxt = S_RUN;
        end else begin
          cnt_nxt = cnt_r + 17'h00001;
        end
        // Top status bit marks the shortest threshold, then downward
        for (i = 0; i < 5; i = i + 1) begin
          if (cnt_nxt >= thr_of(i[2:0])) begin
            status_nxt[4 - i] = 1'b1;
          end
        end
      end
      S_HALT: begin
        if (irq_pending) begin
          state_nxt = S_RUN;
        end
      end
      default: begin
        state_nxt = S_RUN;
      end
    endcase
  end

  // State, counter and status registers; reset waits for oscillation like a stop release
  always @(posedge mclk) begin
    if (reset) begin
      state_r <= S_OSC;
      cnt_r <= 17'h00000;
      settle_status_reg <= `SETTLE_STAT_RST;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      settle_status_reg <= status_nxt;
    end
  end

  // Period select; ordering against stop and status is up to software
  always @(posedge mclk) begin
    if (reset) begin
      settle_period_select_reg <= `SETTLE_SEL_RST;
    end else if (select_wr) begin
      settle_period_select_reg <= select_wdata;
    end
  end

  // Oscillator start tracking: cleared on stop entry, set once the flag reads low.
  // Set wins so a flag already low at stop entry still arms the start.
  // Limitation: a release before the oscillator has stopped waits for it to drop.
  always @(posedge mclk) begin
    if (reset) begin
      osc_low_seen_r <= 1'b1;
    end else if (!osc_ok_s) begin
      osc_low_seen_r <= 1'b1;
    end else if (state_nxt == S_STOP) begin
      osc_low_seen_r <= 1'b0;
    end
  end

  // Registered status outputs follow the next state,
  // so each one changes on the same edge that takes its cause
  always @(posedge mclk) begin
    if (reset) begin
      main_crystal_clock_en_r <= 1'b1;
      cpu_run_r <= 1'b0;
      stop_mode_r <= 1'b0;
      halt_mode_r <= 1'b0;
      settling_r <= 1'b0;
    end else begin
      main_crystal_clock_en_r <= clk_on_in(state_nxt);
      cpu_run_r <= run_in(state_nxt);
      stop_mode_r <= stop_in(state_nxt);
      halt_mode_r <= held_in(state_nxt);
      settling_r <= settle_in(state_nxt);
    end
  end
endmodule // stop_wake_stabilization_counter

// >>> src/settle_defines.vh
// Constants for the stop-release oscillator settling counter
// Functional notes
// - Status bits set one by one from the top bit once each threshold passes; stay set.
// - Counter runs only within the selected period; status shows only thresholds reached there.
// - Wait is counted from oscillation start, not from stop release.
// - Pending unmasked interrupt ends stop or halt at once, but never cuts a settling count short.
// - Stop with pending interrupt drops to halt, resumes after selected wait elapses.
`ifndef SETTLE_DEFINES_VH
`define SETTLE_DEFINES_VH

// Settling thresholds in main clock cycles, shortest first
`define SETTLE_THR0 17'h00800
`define SETTLE_THR1 17'h02000
`define SETTLE_THR2 17'h04000
`define SETTLE_THR3 17'h08000
`define SETTLE_THR4 17'h10000

// Period select codes and reset value
`define SETTLE_SEL_W 3
`define SETTLE_SEL_MAX 3'h4
`define SETTLE_SEL_RST 3'h4

// Status register width; the top bit is the first threshold
`define SETTLE_STAT_W 5
`define SETTLE_STAT_RST 5'h00
`define SETTLE_CNT_W 17

// Controller states
`define ST_RUN 3'h0
`define ST_STOP 3'h1
`define ST_OSC 3'h2
`define ST_COUNT 3'h3
`define ST_HALT 3'h4

`endif

// >>> src/level_sync.v
// Two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
module level_sync (
  input wire mclk,
  input wire reset,
  input wire async_in,
  output reg sync_out_r
);
  reg meta_r;

  // First flop feeds only the second
  always @(posedge mclk) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_out_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_out_r <= meta_r;
    end
  end
endmodule // level_sync

// >>> bench/settle_asserts.sv
// Port checker for the stop-release settling counter
`timescale 1ns/1ps
module settle_asserts (
  input wire mclk,
  input wire reset,
  input wire stop_exec,
  input wire irq_pending,
  input wire main_crystal_osc_ok,
  input wire [2:0] settle_period_select_reg,
  input wire [4:0] settle_status_reg,
  input wire cpu_run_r,
  input wire stop_mode_r,
  input wire halt_mode_r,
  input wire settling_r
);
  // One domain, so clock and reset are given once
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_status_sticky: assert property (!$rose(settling_r) |->
    (settle_status_reg & $past(settle_status_reg)) == $past(settle_status_reg))
    else $error("status bit cleared");
  a_fill_order: assert property (settle_status_reg inside
    {5'h00, 5'h10, 5'h18, 5'h1c, 5'h1e, 5'h1f}) else $error("status out of order");
  a_release_clears: assert property ($rose(settling_r) |-> settle_status_reg == 5'h00)
    else $error("status kept over release");
  // Osc stays low until oscillation starts, so nothing may count yet
  a_wait_osc: assert property (settling_r && !main_crystal_osc_ok |->
    settle_status_reg == 5'h00) else $error("counted before oscillation");
  a_irq_wakes: assert property (stop_mode_r && irq_pending |=>
    !stop_mode_r && settling_r) else $error("stop not released");
  a_stop_halt: assert property (cpu_run_r && stop_exec && irq_pending |=>
    halt_mode_r && !stop_mode_r && !cpu_run_r) else $error("stop not turned to halt");
  a_period_bound: assert property ($rose(cpu_run_r) && $past(settling_r) |->
    settle_status_reg == (5'h1f << (3'h4 - settle_period_select_reg)))
    else $error("status beyond period");
endmodule // settle_asserts
bind stop_wake_stabilization_counter settle_asserts chk_u (.mclk, .reset, .stop_exec,
  .irq_pending, .main_crystal_osc_ok, .settle_period_select_reg, .settle_status_reg,
  .cpu_run_r, .stop_mode_r, .halt_mode_r, .settling_r);

// >>> bench/stop_wake_stabilization_counter_tb.sv
// Self-checking bench for the settling counter
`timescale 1ns/1ps
module stop_wake_stabilization_counter_tb;
  reg mclk = 1'b0, reset = 1'b1, stop_exec = 1'b0, halt_exec = 1'b0, irq = 1'b0;
  reg osc = 1'b0, wr = 1'b0;
  reg [2:0] wd = 3'h0, s;
  wire [2:0] sel;
  wire [4:0] stat;
  wire clk_en, run, stp, hlt, stl;
  integer n_fail = 0, comparisons = 0, k;
  // Short thresholds keep each wake-up to a few dozen cycles
  stop_wake_stabilization_counter #(.THR0(17'h00004), .THR1(17'h00008), .THR2(17'h0000c),
    .THR3(17'h00010), .THR4(17'h00014)) dut_u (.mclk(mclk), .reset(reset),
    .stop_exec(stop_exec), .halt_exec(halt_exec), .irq_pending(irq),
    .main_crystal_osc_ok(osc), .select_wr(wr), .select_wdata(wd),
    .settle_period_select_reg(sel), .settle_status_reg(stat),
    .main_crystal_clock_en_r(clk_en), .cpu_run_r(run), .stop_mode_r(stp),
    .halt_mode_r(hlt), .settling_r(stl));
  // 25 MHz clock
  initial begin
    forever #20 mclk = ~mclk;
  end
  task tick(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task chk(input [4:0] seen, input [4:0] exp); begin
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  end endtask
  // Bounded wait so a stuck counter cannot hang the run
  task wait_run; begin
    k = 0;
    while (run !== 1'b1 && k < 200) begin
      tick(1);
      k = k + 1;
    end
    chk(run, 5'h01);
  end endtask
  task finish_test; begin
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  end endtask
  // Watchdog well beyond the expected run of about 13 us
  initial begin
    #200000;
    n_fail = n_fail + 1;
    finish_test;
  end
  // Main sequence: reset wake, one stop per period, stop and halt with irq
  initial begin
    tick(10);
    reset = 1'b0;
    tick(30);
    chk(stat, 5'h00);
    osc = 1'b1;
    wait_run;
    chk(stat, 5'h1f);
    for (s = 3'h0; s < 3'h5; s = s + 3'h1) begin
      wd = s;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      chk(sel, s);
      stop_exec = 1'b1;
      tick(1);
      stop_exec = 1'b0;
      osc = 1'b0;
      chk({stp, clk_en}, 5'h02);
      irq = 1'b1;
      tick(1);
      irq = 1'b0;
      chk(stat, 5'h00);
      chk(stl, 5'h01);
      tick(30);
      chk(stat, 5'h00);
      osc = 1'b1;
      wait_run;
      chk(stat, 5'h1f << (3'h4 - s));
    end
    irq = 1'b1;
    stop_exec = 1'b1;
    tick(1);
    stop_exec = 1'b0;
    chk({stp, hlt}, 5'h01);
    irq = 1'b0;
    wait_run;
    chk(k[4:0], 5'h15);
    chk(stat, 5'h1f);
    halt_exec = 1'b1;
    tick(1);
    halt_exec = 1'b0;
    chk({run, hlt}, 5'h01);
    irq = 1'b1;
    tick(1);
    chk(run, 5'h01);
    finish_test;
  end
endmodule // stop_wake_stabilization_counter_tb
